/* File: design/acspi_pkg.sv */
// Constants, field layouts and carrier types of the actuator serial frame port.
// Assumes a 100 MHz system clock and a host shift clock that runs only inside frames.
package acspi_pkg;

	// ------------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------------
	localparam int unsigned FRAME_BITS   = 24;
	localparam int unsigned CNT_W        = 5;
	localparam logic [4:0]  FRAME_LEN    = 5'h18;  // Exactly 24 clocks per frame
	localparam logic [4:0]  CNT_MAX      = 5'h1f;
	localparam int unsigned SEL_BIT      = 0;
	localparam int unsigned CTRL_LO      = 1;
	localparam int unsigned N_GATES      = 17;
	localparam int unsigned N_BRIDGES    = 6;
	localparam int unsigned N_DRV        = 11;
	localparam int unsigned CM_LO        = 18;
	localparam int unsigned REC_DIS_BIT  = 20;
	localparam int unsigned DUTY_BIT     = 21;
	localparam int unsigned CLR_BIT      = 22;
	localparam int unsigned EN_BIT       = 23;
	localparam int unsigned REC_LO       = 1;   // Second input register: recovery bits
	localparam int unsigned PWM_LO       = 12;  // Second input register: PWM enables
	localparam int unsigned PWM_INPUT_TWO_DRV_A   = 8;   // Drivers nine and ten follow PWM two
	localparam int unsigned PWM_INPUT_TWO_DRV_B   = 9;
	localparam logic [23:0] IN_REG_RESET = 24'h000000;

	// ------------------------------------------------------------------
	// Status layout, bits 1 to 22 of each status word
	// ------------------------------------------------------------------
	localparam int unsigned ST_OV_BIT    = 22;
	localparam int unsigned ST_UV_BIT    = 21;
	localparam int unsigned ST_TSD_BIT   = 20;
	localparam int unsigned ST_TW_BIT    = 19;
	localparam int unsigned ST_OC_LO     = 1;
	localparam int unsigned ST_OL_LO     = 1;
	localparam logic [21:0] ST_RESET     = 22'h000000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned SYS_CLK_MHZ     = 100;
	localparam int unsigned INT_CLK_MHZ     = 2;
	localparam int unsigned INT_CLK_HALF    = SYS_CLK_MHZ / (2 * INT_CLK_MHZ);
	localparam int unsigned RETRY_PERIOD_NS = 10240;
	localparam int unsigned RETRY_CYC       = RETRY_PERIOD_NS * SYS_CLK_MHZ / 1000;
	localparam int unsigned DUTY_LO_CYC     = RETRY_CYC / 8;  // About 12 percent
	localparam int unsigned DUTY_HI_CYC     = RETRY_CYC / 4;  // 25 percent

	// Test-mode sources for the serial output
	typedef enum logic [2:0] {
		ACSPI_SRC_FAULT,
		ACSPI_SRC_DATA,
		ACSPI_SRC_SCLK,
		ACSPI_SRC_INTCLK,
		ACSPI_SRC_PWM_INPUT_ONE,
		ACSPI_SRC_PWM_INPUT_TWO
	} acspi_test_src_t;

	// Diagnostic events from the power stages
	typedef struct packed {
		logic        overvoltage;
		logic        undervoltage;
		logic        thermal_shutdown_flag;
		logic        temperature_warning_flag;
		logic [10:0] over_current;
		logic [10:0] open_load;
	} acspi_diag_t;

endpackage

/* File: design/acspi_frame_port.sv */
// Serial frame port with input registers, status latching and driver gating.
// Assumes a mode-0 host shift clock, analog event pins and a high-voltage test detector.
//
// Behaviour
// RULE_01 - Sample serial input on rising shift edges, change serial output on falling ones.
// RULE_02 - Frames move least significant bit first in both directions.
// RULE_03 - Serial output floats while chip select is high; a low opens a frame.
// RULE_04 - With chip select low and no clocks, serial output shows the fault bit.
// RULE_05 - Fault bit combines status bits 1 to 22; polarity is a parameter.
// RULE_06 - Every rising shift edge in a frame enters a 24-bit shift register.
// RULE_07 - Frames of any length other than 24 clocks change nothing.
// RULE_08 - Valid frame is copied to the input register chosen by bit 0 at frame end.
// RULE_09 - First rising edge loads the chosen status word; falling edges shift it out.
// RULE_10 - Bit 0 picks both the written input register and the returned status word.
// RULE_11 - Bits 1 to 17 drive one output gate each.
// RULE_12 - Bit 23 low in an accepted frame puts the device into standby.
// RULE_13 - Bits 18 and 19 select the current monitor source.
// RULE_14 - Bit 22 clears both status words at frame end, after they were sent.
// RULE_15 - Over-current disables its driver; without recovery it waits for a clear.
// RULE_16 - Thermal shutdown floats every driver until its status bit is cleared.
// RULE_17 - High and low side of one half bridge are never on together.
// RULE_18 - Test mode drives the serial output instead of floating it.
// RULE_19 - In test mode, both-on pairs of bridges 1 to 3 pick the output source.
// RULE_20 - Test mode requests over-current thresholds reduced fourfold.
// RULE_21 - The host gives each device its own chip select; no daisy chain.
// RULE_22 - With recovery disable set, supply faults hold drivers off until cleared.
// RULE_23 - Recovery drivers retry after over-current with about 12 or 25 percent duty.
// RULE_24 - With PWM enable set, a driver follows its control bit AND its PWM input.
// RULE_25 - The frame bit counter restarts with every new frame.
`timescale 1ns/1ns

module acspi_frame_port #(
	parameter bit FAULT_NOR = 1'b0
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  reset_in,
	input  wire logic                  shift_clk_in,
	input  wire logic                  chip_select_n_in,
	input  wire logic                  serial_in_in,
	input  wire logic                  test_mode_in,
	input  wire logic                  pwm_input_one_in,
	input  wire logic                  pwm_input_two_in,
	input  wire acspi_pkg::acspi_diag_t diag_in,
	output logic                       serial_out_out,
	output logic                       serial_out_oe_out,
	output logic [16:0]                gate_out,
	output logic [1:0]                 current_monitor_sel_out,
	output logic                       standby_out,
	output logic                       oc_threshold_quarter_out
);
	import acspi_pkg::*;

	// ------------------------------------------------------------------
	// Link domain: shift clock
	// ------------------------------------------------------------------
	logic [23:0] rx_shift_reg;
	logic [4:0]  bit_cnt_reg;
	logic        frame_open_reg;
	logic        frame_tog_reg;
	logic [23:0] tx_word_reg;
	logic [4:0]  tx_idx_reg;
	logic [23:0] snap0_reg;
	logic [23:0] snap1_reg;

	// Open flag falls the moment chip select rises, so the next frame starts fresh
	always_ff @(posedge shift_clk_in or posedge reset_in or posedge chip_select_n_in) begin
		if (reset_in || chip_select_n_in) begin
			frame_open_reg <= 1'b0;  // RULE_03
		end else begin
			frame_open_reg <= 1'b1;
		end
	end

	// Count clocks; the first edge of a frame restarts at one and saturates at 31
	always_ff @(posedge shift_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bit_cnt_reg <= 5'h00;
		end else if (!frame_open_reg) begin
			bit_cnt_reg <= 5'h01;  // RULE_25
		end else if (bit_cnt_reg != CNT_MAX) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;  // RULE_07
		end
	end

	// Data enters at the top so the first bit ends in bit 0
	always_ff @(posedge shift_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_shift_reg <= 24'h000000;
		end else begin
			rx_shift_reg <= {serial_in_in, rx_shift_reg[23:1]};  // RULE_01 RULE_02 RULE_06
		end
	end

	// Toggle tells the system side that this frame saw at least one clock
	always_ff @(posedge shift_clk_in or posedge reset_in) begin
		if (reset_in) begin
			frame_tog_reg <= 1'b0;
		end else if (!frame_open_reg) begin
			frame_tog_reg <= ~frame_tog_reg;
		end
	end

	// First edge latches the status word picked by the incoming bit 0
	always_ff @(posedge shift_clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_word_reg <= 24'h000000;
		end else if (!frame_open_reg) begin
			tx_word_reg <= serial_in_in ? snap1_reg : snap0_reg;  // RULE_09 RULE_10
		end
	end

	// Falling edges step through the word, low bit first
	always_ff @(negedge shift_clk_in or posedge reset_in or posedge chip_select_n_in) begin
		if (reset_in || chip_select_n_in) begin
			tx_idx_reg <= 5'h00;
		end else if (frame_open_reg && tx_idx_reg != 5'(FRAME_BITS - 1)) begin  // Stay on bit 23
			tx_idx_reg <= tx_idx_reg + 5'h01;  // RULE_01 RULE_02 RULE_09
		end
	end

	// ------------------------------------------------------------------
	// Synchronisers into the system domain
	// ------------------------------------------------------------------
	logic        cs_meta_reg, cs_sync_reg, cs_prev_reg;
	logic        tog_meta_reg, tog_sync_reg, tog_seen_reg;
	logic        test_meta_reg, test_sync_reg;
	logic [3:0]  pin_meta_reg, pin_sync_reg;
	acspi_diag_t diag_meta_reg, diag_sync_reg;

	// Two flops per asynchronous input; only the second stage is read
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cs_meta_reg   <= 1'b1;
			cs_sync_reg   <= 1'b1;
			tog_meta_reg  <= 1'b0;
			tog_sync_reg  <= 1'b0;
			test_meta_reg <= 1'b0;
			test_sync_reg <= 1'b0;
			pin_meta_reg  <= 4'h0;
			pin_sync_reg  <= 4'h0;
			diag_meta_reg <= '0;
			diag_sync_reg <= '0;
		end else begin
			cs_meta_reg   <= chip_select_n_in;
			cs_sync_reg   <= cs_meta_reg;
			tog_meta_reg  <= frame_tog_reg;
			tog_sync_reg  <= tog_meta_reg;
			test_meta_reg <= test_mode_in;
			test_sync_reg <= test_meta_reg;
			pin_meta_reg  <= {pwm_input_two_in, pwm_input_one_in, shift_clk_in, serial_in_in};
			pin_sync_reg  <= pin_meta_reg;
			diag_meta_reg <= diag_in;
			diag_sync_reg <= diag_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Frame acceptance and input registers
	// ------------------------------------------------------------------
	logic [23:0] in0_reg, in1_reg;
	logic        frame_end, accept, wr0, wr1, clr_status;

	// Link data is quiet by the time the chip select rise has crossed over
	assign frame_end  = cs_sync_reg && !cs_prev_reg;
	assign accept     = frame_end && (tog_sync_reg != tog_seen_reg) && (bit_cnt_reg == FRAME_LEN);
	assign wr0        = accept && !rx_shift_reg[SEL_BIT];  // RULE_10
	assign wr1        = accept && rx_shift_reg[SEL_BIT];
	assign clr_status = wr0 && rx_shift_reg[CLR_BIT];  // RULE_14

	// Edge and frame bookkeeping
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cs_prev_reg  <= 1'b1;
			tog_seen_reg <= 1'b0;
		end else begin
			cs_prev_reg  <= cs_sync_reg;
			tog_seen_reg <= frame_end ? tog_sync_reg : tog_seen_reg;
		end
	end

	// Only an exact 24-clock frame reaches an input register
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			in0_reg <= IN_REG_RESET;
			in1_reg <= IN_REG_RESET;
		end else begin
			if (wr0) begin
				in0_reg <= rx_shift_reg;  // RULE_07 RULE_08
			end
			if (wr1) begin
				in1_reg <= rx_shift_reg;  // RULE_07 RULE_08
			end
		end
	end

	// ------------------------------------------------------------------
	// Status words
	// ------------------------------------------------------------------
	logic [22:1] st0_reg, st1_reg, ev0, ev1;
	logic        fault_reg;

	// Event map into bits 1 to 22
	always_comb begin
		ev0 = '0;
		ev1 = '0;
		ev0[ST_OV_BIT]  = diag_sync_reg.overvoltage;
		ev0[ST_UV_BIT]  = diag_sync_reg.undervoltage;
		ev0[ST_TSD_BIT] = diag_sync_reg.thermal_shutdown_flag;
		ev0[ST_TW_BIT]  = diag_sync_reg.temperature_warning_flag;
		ev0[ST_OC_LO +: N_DRV] = diag_sync_reg.over_current;
		ev1[ST_OL_LO +: N_DRV] = diag_sync_reg.open_load;
	end

	// Sticky flags; an event in the clearing cycle survives the clear
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st0_reg <= ST_RESET;
			st1_reg <= ST_RESET;
		end else if (clr_status) begin
			st0_reg <= ev0;  // RULE_14
			st1_reg <= ev1;
		end else begin
			st0_reg <= st0_reg | ev0;
			st1_reg <= st1_reg | ev1;
		end
	end

	// Fault summary over both words
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			fault_reg <= FAULT_NOR;
		end else begin
			fault_reg <= (|{st0_reg, st1_reg}) ^ FAULT_NOR;  // RULE_05
		end
	end

	// Snapshots freeze while a frame is open, so the link side reads steady words
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			snap0_reg <= 24'h800000;
			snap1_reg <= 24'h800000;
		end else if (cs_sync_reg) begin
			snap0_reg <= {1'b1, st0_reg, fault_reg};
			snap1_reg <= {1'b1, st1_reg, fault_reg};
		end
	end

	// ------------------------------------------------------------------
	// Driver gating
	// ------------------------------------------------------------------
	logic [9:0]  retry_cnt_reg;
	logic        retry_win, supply_ok, active;
	logic [16:0] gate_next;

	// Free-running retry period; recovery drivers with a latched over-current are on only in its early window
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			retry_cnt_reg <= 10'h000;
		end else begin
			retry_cnt_reg <= (retry_cnt_reg == 10'(RETRY_CYC - 1)) ? 10'h000 : retry_cnt_reg + 10'h001;
		end
	end

	assign retry_win = retry_cnt_reg < (in0_reg[DUTY_BIT] ? 10'(DUTY_HI_CYC) : 10'(DUTY_LO_CYC));
	// Live supply fault always blocks; latched one blocks too when recovery is disabled
	assign supply_ok = !(diag_sync_reg.overvoltage || diag_sync_reg.undervoltage)
		&& !(in0_reg[REC_DIS_BIT] && (st0_reg[ST_OV_BIT] || st0_reg[ST_UV_BIT]));  // RULE_22
	assign active = in0_reg[EN_BIT] && !st0_reg[ST_TSD_BIT] && supply_ok;  // RULE_12 RULE_16

	// Gate g belongs to a half bridge for g below 12, else to a high-side driver
	function automatic int unsigned drv_of(input int unsigned g);
		drv_of = (g < 2 * N_BRIDGES) ? g / 2 : g - N_BRIDGES;
	endfunction

	// True when both sides of half bridge b are requested
	function automatic logic both_on(input logic [23:0] r, input int unsigned b);
		both_on = r[CTRL_LO + 2 * b] && r[CTRL_LO + 2 * b + 1];
	endfunction

	generate
		for (genvar g = 0; g < N_GATES; g++) begin : g_gate
			localparam int unsigned D = drv_of(g);
			logic oc_ok, pwm_ok, xbar_ok;
			assign oc_ok  = !st0_reg[ST_OC_LO + D] || (in1_reg[REC_LO + D] && retry_win);  // RULE_15 RULE_23
			assign pwm_ok = !in1_reg[PWM_LO + D]
				|| ((D == PWM_INPUT_TWO_DRV_A || D == PWM_INPUT_TWO_DRV_B) ? pin_sync_reg[3] : pin_sync_reg[2]);  // RULE_24
			assign xbar_ok = (g >= 2 * N_BRIDGES) || !both_on(in0_reg, g / 2);  // RULE_17
			assign gate_next[g] = in0_reg[CTRL_LO + g] && active && oc_ok && pwm_ok && xbar_ok;  // RULE_11
		end
	endgenerate

	// Registered outputs to the power stages
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			gate_out                 <= '0;
			current_monitor_sel_out  <= 2'h0;
			standby_out              <= 1'b1;
			oc_threshold_quarter_out <= 1'b0;
		end else begin
			gate_out                 <= gate_next;
			current_monitor_sel_out  <= in0_reg[CM_LO +: 2];  // RULE_13
			standby_out              <= !in0_reg[EN_BIT];  // RULE_12
			oc_threshold_quarter_out <= test_sync_reg;  // RULE_20
		end
	end

	// ------------------------------------------------------------------
	// Test-mode multiplexer
	// ------------------------------------------------------------------
	logic [4:0]      int_cnt_reg;
	logic            int_clk_reg, test_bit_reg;
	acspi_test_src_t test_src;

	// Pair code from bridges 1 to 3; unlisted codes fall back to the fault bit
	function automatic acspi_test_src_t pick_src(input logic [23:0] r);
		case ({both_on(r, 2), both_on(r, 1), both_on(r, 0)})
			3'h1:    pick_src = ACSPI_SRC_DATA;
			3'h2:    pick_src = ACSPI_SRC_SCLK;
			3'h3:    pick_src = ACSPI_SRC_INTCLK;
			3'h4:    pick_src = ACSPI_SRC_PWM_INPUT_ONE;
			3'h5:    pick_src = ACSPI_SRC_PWM_INPUT_TWO;
			default: pick_src = ACSPI_SRC_FAULT;
		endcase
	endfunction

	assign test_src = pick_src(in0_reg);  // RULE_19

	// Internal 2 MHz reference from the system clock
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			int_cnt_reg <= 5'h00;
			int_clk_reg <= 1'b0;
		end else if (int_cnt_reg == 5'(INT_CLK_HALF - 1)) begin
			int_cnt_reg <= 5'h00;
			int_clk_reg <= ~int_clk_reg;
		end else begin
			int_cnt_reg <= int_cnt_reg + 5'h01;
		end
	end

	// Observed pins are sampled, so their edges show up two or three cycles late; the internal clock and fault bit one cycle late
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			test_bit_reg <= 1'b0;
		end else begin
			case (test_src)
				ACSPI_SRC_DATA:   test_bit_reg <= pin_sync_reg[0];
				ACSPI_SRC_SCLK:   test_bit_reg <= pin_sync_reg[1];
				ACSPI_SRC_INTCLK: test_bit_reg <= int_clk_reg;
				ACSPI_SRC_PWM_INPUT_ONE:   test_bit_reg <= pin_sync_reg[2];
				ACSPI_SRC_PWM_INPUT_TWO:   test_bit_reg <= pin_sync_reg[3];
				default:          test_bit_reg <= fault_reg;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Serial output pin
	// ------------------------------------------------------------------
	// Enable and early fault bit follow the pin itself; waiting for a clock would miss polls
	assign serial_out_oe_out = !chip_select_n_in || test_sync_reg;  // RULE_03 RULE_18
	assign serial_out_out = test_sync_reg ? test_bit_reg
		: frame_open_reg ? tx_word_reg[tx_idx_reg] : fault_reg;  // RULE_04 RULE_09

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_frame_taken;
		accept && !rx_shift_reg[SEL_BIT];
	endsequence

	sequence s_reg_loaded;
		##1 in0_reg == $past(rx_shift_reg);
	endsequence

	write_valid_a: assert property (s_frame_taken |-> s_reg_loaded)  // RULE_08
		else $error("input register 0 missed an accepted frame");

	write_only_a: assert property ($changed(in0_reg) |-> $past(wr0))  // RULE_07
		else $error("input register 0 changed without a 24-clock frame");

	status_clear_a: assert property (clr_status |=> ((st0_reg & ~$past(ev0)) == '0))  // RULE_14
		else $error("status word 0 not cleared by reset bit");

	cross_block_a: assert property (  // RULE_17
		both_on(in0_reg, 0) || both_on(in0_reg, 5) |=> ##1 !(gate_out[0] && gate_out[1])
			&& !(gate_out[10] && gate_out[11]))
		else $error("both sides of a half bridge on");

	thermal_off_a: assert property (st0_reg[ST_TSD_BIT] |=> gate_out == '0)  // RULE_16
		else $error("driver on during thermal shutdown");

	standby_off_a: assert property (!in0_reg[EN_BIT] |=> standby_out && gate_out == '0)  // RULE_12
		else $error("driver on during standby");

	oc_lock_a: assert property (  // RULE_15
		st0_reg[ST_OC_LO] && !in1_reg[REC_LO] |=> !gate_out[0] && !gate_out[1])
		else $error("over-current driver one not held off");

	test_drive_a: assert property (test_sync_reg |-> serial_out_oe_out)  // RULE_18
		else $error("serial output floating in test mode");

	cm_follow_a: assert property ($changed(in0_reg[CM_LO +: 2]) |=>  // RULE_13
		current_monitor_sel_out == $past(in0_reg[CM_LO +: 2]))
		else $error("monitor select lags input register");

	first_count_a: assert property (@(posedge shift_clk_in) disable iff (reset_in)  // RULE_25
		!frame_open_reg && !chip_select_n_in |=> bit_cnt_reg == 5'h01)
		else $error("frame counter did not restart");

endmodule

/* File: tb/acspi_host_model.sv */
// Host controller model: mode-0 master with its own chip select, link clock 80 ns.
// Assumes the bench calls frame and poll one at a time.
`timescale 1ns/1ns

module acspi_host_model (
	output logic       shift_clk_out,
	output logic       chip_select_n_out,
	output logic       serial_in_out,
	input  wire logic  serial_out_in,
	input  wire logic  serial_out_oe_in
);
	// Link clock idles low and stands still between frames
	initial begin
		shift_clk_out     = 1'b0;
		chip_select_n_out = 1'b1;
		serial_in_out     = 1'b0;
	end

	// One frame of n clocks; bits beyond 24 carry zero, rx holds the first 24 bits
	task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h000000;
		#3 chip_select_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in_out = (i < 24) ? tx[i] : 1'b0;
			#40 shift_clk_out = 1'b1;
			#20 if (i < 24) rx[i] = serial_out_in;
			#20 shift_clk_out = 1'b0;
		end
		#40 chip_select_n_out = 1'b1;
		// Released line shows the inverse so a stale value cannot pass
		serial_in_out = ~serial_in_out;
		#80;
	endtask

	// Fault poll: chip select low with no clocks
	task automatic poll(output logic f, output logic oe);
		chip_select_n_out = 1'b0;
		#20 f = serial_out_in;
		oe = serial_out_oe_in;
		chip_select_n_out = 1'b1;
		#80;
	endtask
endmodule

/* File: tb/actuator_spi_frame_port_tb.sv */
// Self-checking bench for the actuator serial frame port.
// Assumes the host model in acspi_host_model.sv and the package defaults.
`timescale 1ns/1ns

module actuator_spi_frame_port_tb;
	import acspi_pkg::*;

	logic            sys_clk_in = 1'b0;
	logic            reset_in   = 1'b1;
	logic            sclk, chip_select_n, sdi, sdo, sdo_oe;
	logic            test_mode_in = 1'b0;
	logic            pwm_input_one = 1'b0;
	logic            pwm_input_two = 1'b0;
	acspi_diag_t     diag = '0;
	logic [16:0]     gate;
	logic [1:0]      msel;
	logic            standby, quarter, f, oe;
	logic [23:0]     rx;
	int              miscompares = 0;
	int              samples_checked = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	acspi_host_model host (.shift_clk_out(sclk), .chip_select_n_out(chip_select_n),
		.serial_in_out(sdi), .serial_out_in(sdo), .serial_out_oe_in(sdo_oe));

	acspi_frame_port dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .shift_clk_in(sclk),
		.chip_select_n_in(chip_select_n), .serial_in_in(sdi), .test_mode_in(test_mode_in),
		.pwm_input_one_in(pwm_input_one), .pwm_input_two_in(pwm_input_two), .diag_in(diag),
		.serial_out_out(sdo), .serial_out_oe_out(sdo_oe), .gate_out(gate),
		.current_monitor_sel_out(msel), .standby_out(standby),
		.oc_threshold_quarter_out(quarter));

	// ------------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Settling time covers sync, register write and gating stages
	task automatic settle();
		repeat (8) @(posedge sys_clk_in);
	endtask

	task automatic wr(input logic [23:0] d, input int n);
		host.frame(d, n, rx);
		settle();
	endtask

	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_write();
		chk({gate, msel, standby, sdo_oe}, {17'h0, 2'h0, 1'b1, 1'b0});
		wr(24'h88200c, 24);
		chk({gate, msel, standby}, {17'h01006, 2'h2, 1'b0});
		wr(24'h000000, 23);
		chk({gate, standby}, {17'h01006, 1'b0});
		wr(24'h000000, 25);
		chk({gate, standby}, {17'h01006, 1'b0});
		wr(24'h802006, 24);
		chk(gate, 17'h01000);
		wr(24'h000000, 24);
		chk(standby, 1'b1);
		$display("test write done");
	endtask

	task automatic t_status();
		@(posedge sys_clk_in) diag.over_current[0] <= 1'b1;
		diag.open_load[2] <= 1'b1;
		settle();
		host.poll(f, oe);
		chk({f, oe}, 2'b11);
		host.frame(24'h800000, 24, rx);
		chk(rx, 24'h800003);
		host.frame(24'h000001, 24, rx);
		chk(rx, 24'h800009);
		@(posedge sys_clk_in) diag <= '0;
		settle();
		host.frame(24'hc00000, 24, rx);
		chk(rx, 24'h800003);
		settle();
		host.frame(24'h800000, 24, rx);
		chk(rx, 24'h800000);
		host.poll(f, oe);
		chk(f, 1'b0);
		$display("test status done");
	endtask

	task automatic t_thermal();
		wr(24'h802000, 24);
		chk(gate, 17'h01000);
		@(posedge sys_clk_in) diag.thermal_shutdown_flag <= 1'b1;
		settle();
		chk(gate, 17'h0);
		@(posedge sys_clk_in) diag.thermal_shutdown_flag <= 1'b0;
		settle();
		chk(gate, 17'h0);
		wr(24'hc02000, 24);
		chk(gate, 17'h01000);
		$display("test thermal done");
	endtask

	// Driver seven: PWM gating, over-current lock and retry, supply lock
	task automatic t_protect();
		logic [23:0] cnt;
		cnt = 24'h000000;
		wr(24'h040001, 24);
		chk(gate, 17'h0);
		@(posedge sys_clk_in) pwm_input_one <= 1'b1;
		settle();
		chk(gate, 17'h01000);
		wr(24'h000001, 24);
		@(posedge sys_clk_in) diag.over_current[6] <= 1'b1;
		settle();
		@(posedge sys_clk_in) diag <= '0;
		settle();
		chk(gate, 17'h0);
		wr(24'h000081, 24);
		// One whole retry period, so the on count is exact
		repeat (1024) @(negedge sys_clk_in) cnt = cnt + gate[12];
		chk(cnt, 24'h000080);
		wr(24'hd02000, 24);
		chk(gate, 17'h01000);
		@(posedge sys_clk_in) diag.undervoltage <= 1'b1;
		settle();
		chk(gate, 17'h0);
		@(posedge sys_clk_in) diag <= '0;
		settle();
		chk(gate, 17'h0);
		wr(24'hc02000, 24);
		chk(gate, 17'h01000);
		$display("test protect done");
	endtask

	task automatic t_test_mode();
		// Frame ends with serial input high, so the fault source would read differently
		wr(24'h000006, 24);
		@(posedge sys_clk_in) test_mode_in <= 1'b1;
		settle();
		chk({sdo_oe, quarter}, 2'b11);
		chk(sdo, host.serial_in_out);
		wr(24'h000060, 24);
		chk(sdo, pwm_input_one);
		@(posedge sys_clk_in) pwm_input_one <= ~pwm_input_one;
		settle();
		chk(sdo, pwm_input_one);
		@(posedge sys_clk_in) test_mode_in <= 1'b0;
		settle();
		chk({sdo_oe, quarter}, 2'b00);
		$display("test test_mode done");
	endtask

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		t_write();
		t_status();
		t_thermal();
		t_protect();
		t_test_mode();
		close_out();
	end

	// Whole run takes about 50 us; allow ample margin
	initial begin
		#500000;
		miscompares++;
		close_out();
	end
endmodule
